// ==== hdl/hdlc_rx_dma_pkg.sv ====
// Constants and types of the receive descriptor mover
`default_nettype none
package hdlc_rx_dma_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFS_TABLE_BASE = 8'h00;
  localparam logic [7:0] OFS_RX_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CAUSE = 8'h0C;
  localparam logic [23:0] TABLE_BASE_RST = 24'h00_0000;
  localparam logic [15:0] RX_CMD_RST = 16'h0000;
  // Command register fields
  localparam int CMD_START_BIT = 8;
  localparam int CMD_CONT_BIT = 9;
  localparam int CMD_ABORT_BIT = 10;
  localparam int CMD_RX_BIT = 5;
  // Cause register fields
  localparam int CAUSE_QSTOP_BIT = 0;
  localparam int CAUSE_BDONE_BIT = 1;
  // Channel table entry layout
  localparam int ENTRY_SHIFT = 3;
  localparam logic [23:0] ENT_TX_HI = 24'h00_0000;
  localparam logic [23:0] ENT_TX_LO = 24'h00_0002;
  localparam logic [23:0] ENT_RX_HI = 24'h00_0004;
  localparam logic [23:0] ENT_RX_LO = 24'h00_0006;
  // Receive descriptor layout
  localparam int DESC_WORDS = 5;
  localparam logic [23:0] DESC_STATUS = 24'h00_000A;
  localparam int IBC_BIT = 13;
  localparam int EOQ_BIT = 12;
  localparam int LEN_W = 12;
  localparam int CNT_W = 13;
  // Status word flags: end_of_packet_ok, abort, overflow, check sequence
  localparam logic [3:0] ST_NONE = 4'h0;
  localparam logic [3:0] ST_OK = 4'h8;
  localparam logic [3:0] ST_CRC = 4'h9;
  localparam logic [3:0] ST_ABORT = 4'h4;
  localparam logic [3:0] ST_OVF = 4'h6;
  localparam logic [3:0] ST_ODD = 4'h5;
  // Frame end kinds on the receive stream
  typedef enum logic [2:0] {
    END_OK = 3'h0,
    END_CRC = 3'h1,
    END_ABORT = 3'h2,
    END_OVF = 3'h3,
    END_ODD = 3'h4
  } end_kind_t;
  typedef enum {
    S_IDLE, S_TBL_HI, S_TBL_LO, S_DESC, S_HALT, S_STAT0,
    S_FILL, S_WORD, S_STAT, S_TXW_HI, S_TXW_LO
  } state_t;
endpackage
`default_nettype wire

// ==== hdl/hdlc_rx_descriptor_dma.sv ====
// Receive descriptor mover with channel table access and AHB-Lite registers
//
// Contract
// - Start on any of 32 channels reads its table entry once the sequencer is idle or halted.
// - Entry is eight bytes: tx high +0, low +2, rx high +4, low +6.
// - Bit 0 of table pointer low words is ignored when forming addresses.
// - Shared memory is accessed as 16-bit words, always word aligned.
// - First transmit descriptor address is written back into the channel entry.
// - First five descriptor words are only read, never written.
// - Status word at offset ten is written only by this logic.
// - Word 0 control and size, words 1-2 buffer, words 3-4 next descriptor.
// - Buffer size counts 16-bit words, up to 2048.
// - Zero buffer size skips straight to the next descriptor.
// - Status carries a received byte count.
// - Buffer-done enable raises an interrupt when the buffer completes.
// - Queue-stop halts at once, sets cause, waits for a command.
// - Good frame end writes frame-end flag only.
// - Bad check sequence writes frame-end and check-sequence flags.
// - Flags clear: nonzero count is full buffer, zero is in progress.
// - Abort writes only the abort flag.
// - FIFO overflow writes abort and overflow flags.
// - Non-integer byte frame writes abort and check-sequence flags.
`default_nettype none
module hdlc_rx_descriptor_dma #(
  parameter int MAX_WORDS = 2048
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output logic mem_we,
  output logic [23:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  input wire logic rx_nobyte,
  input wire logic [2:0] rx_end_kind,
  output logic rx_ready,
  input wire logic tx_store_valid,
  input wire logic [4:0] tx_store_chan,
  input wire logic [23:0] tx_store_addr,
  output logic tx_store_ready,
  output logic tx_desc_valid,
  output logic [4:0] tx_desc_chan,
  output logic [23:0] tx_desc_addr,
  output logic buffer_done_irq,
  output logic queue_stop_irq
);
  hdlc_rx_dma_pkg::state_t state_q;
  logic [23:0] table_base_reg_q;
  logic [15:0] rx_command_reg_q;
  logic [1:0] cause_q;
  logic start_pend_q, cont_pend_q, abort_pend_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [5:0] chan_q;
  logic [4:0] txs_chan_q;
  logic [23:0] txs_addr_q;
  logic [2:0] dw_q;
  logic [7:0] hi_q;
  logic [23:0] rx_descriptor_pointer_q;
  logic [23:0] rx_buffer_pointer_q;
  logic [23:0] next_rx_descriptor_pointer_q;
  logic [hdlc_rx_dma_pkg::LEN_W-1:0] buffer_length_words_q;
  logic [hdlc_rx_dma_pkg::LEN_W-1:0] words_q;
  logic buffer_done_irq_enable_q, queue_stop_flag_q;
  logic [hdlc_rx_dma_pkg::CNT_W-1:0] received_byte_count_q;
  logic [7:0] lo_q;
  logic have_lo_q, end_pend_q;
  logic [2:0] end_kind_q;
  logic [15:0] word_q;
  logic done, take, bus_wr, set_start, set_cont, set_abort;
  logic take_start, take_cont, take_txs;
  logic op_need, op_we;
  logic [23:0] op_addr, ent_addr;
  logic [15:0] op_wdata;
  logic [3:0] flags;
  logic [31:0] rd_mux;
  logic [hdlc_rx_dma_pkg::LEN_W-1:0] len_eff;

  assign done = mem_req & mem_ack;
  assign take = rx_valid & rx_ready;
  assign bus_wr = wr_pend_q && (wr_addr_q == hdlc_rx_dma_pkg::OFS_RX_CMD);
  assign set_start = bus_wr & hwdata[hdlc_rx_dma_pkg::CMD_START_BIT];
  assign set_cont = bus_wr & hwdata[hdlc_rx_dma_pkg::CMD_CONT_BIT];
  assign set_abort = bus_wr & hwdata[hdlc_rx_dma_pkg::CMD_ABORT_BIT];
  assign take_start = start_pend_q && (state_q == hdlc_rx_dma_pkg::S_IDLE
    || state_q == hdlc_rx_dma_pkg::S_HALT);
  assign take_cont = cont_pend_q && state_q == hdlc_rx_dma_pkg::S_HALT && !start_pend_q;
  assign take_txs = tx_store_valid & tx_store_ready;
  assign ent_addr = table_base_reg_q
    + {16'h0000, chan_q[4:0], 3'b000};
  assign len_eff = (buffer_length_words_q > hdlc_rx_dma_pkg::LEN_W'(MAX_WORDS))
    ? hdlc_rx_dma_pkg::LEN_W'(MAX_WORDS) : buffer_length_words_q;

  // Status flags chosen by how the buffer ended
  always_comb begin
    flags = hdlc_rx_dma_pkg::ST_NONE;
    if (end_pend_q) begin
      unique case (end_kind_q)
        hdlc_rx_dma_pkg::END_OK: flags = hdlc_rx_dma_pkg::ST_OK;
        hdlc_rx_dma_pkg::END_CRC: flags = hdlc_rx_dma_pkg::ST_CRC;
        hdlc_rx_dma_pkg::END_OVF: flags = hdlc_rx_dma_pkg::ST_OVF;
        hdlc_rx_dma_pkg::END_ODD: flags = hdlc_rx_dma_pkg::ST_ODD;
        default: flags = hdlc_rx_dma_pkg::ST_ABORT;
      endcase
    end
  end

  // Memory operation wanted by the current state
  always_comb begin
    op_need = 1'b1;
    op_we = 1'b0;
    op_addr = rx_descriptor_pointer_q;
    op_wdata = 16'h0000;
    unique case (state_q)
      hdlc_rx_dma_pkg::S_TBL_HI: op_addr = ent_addr + (chan_q[hdlc_rx_dma_pkg::CMD_RX_BIT]
        ? hdlc_rx_dma_pkg::ENT_RX_HI : hdlc_rx_dma_pkg::ENT_TX_HI);
      hdlc_rx_dma_pkg::S_TBL_LO: op_addr = ent_addr + (chan_q[hdlc_rx_dma_pkg::CMD_RX_BIT]
        ? hdlc_rx_dma_pkg::ENT_RX_LO : hdlc_rx_dma_pkg::ENT_TX_LO);
      hdlc_rx_dma_pkg::S_DESC: op_addr = rx_descriptor_pointer_q
        + {20'h0_0000, dw_q, 1'b0};
      hdlc_rx_dma_pkg::S_STAT0: begin
        op_we = 1'b1;
        op_addr = rx_descriptor_pointer_q + hdlc_rx_dma_pkg::DESC_STATUS;
      end
      hdlc_rx_dma_pkg::S_WORD: begin
        op_we = 1'b1;
        op_addr = rx_buffer_pointer_q + {11'h000, words_q, 1'b0};
        op_wdata = word_q;
      end
      hdlc_rx_dma_pkg::S_STAT: begin
        op_we = 1'b1;
        op_addr = rx_descriptor_pointer_q + hdlc_rx_dma_pkg::DESC_STATUS;
        op_wdata = {flags, received_byte_count_q[11:0]};
      end
      hdlc_rx_dma_pkg::S_TXW_HI: begin
        op_we = 1'b1;
        op_addr = table_base_reg_q + {16'h0000, txs_chan_q, 3'b000}
          + hdlc_rx_dma_pkg::ENT_TX_HI;
        op_wdata = {8'h00, txs_addr_q[23:16]};
      end
      hdlc_rx_dma_pkg::S_TXW_LO: begin
        op_we = 1'b1;
        op_addr = table_base_reg_q + {16'h0000, txs_chan_q, 3'b000}
          + hdlc_rx_dma_pkg::ENT_TX_LO;
        op_wdata = {txs_addr_q[15:1], 1'b0};
      end
      default: op_need = 1'b0;
    endcase
  end

  // Shared memory port, one word transfer at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 24'h00_0000;
      mem_wdata <= 16'h0000;
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end else if (op_need) begin
      mem_req <= 1'b1;
      mem_we <= op_we;
      mem_addr <= {op_addr[23:1], 1'b0};
      mem_wdata <= op_wdata;
    end
  end

  // Main sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= hdlc_rx_dma_pkg::S_IDLE;
      chan_q <= 6'h00;
      dw_q <= 3'h0;
      hi_q <= 8'h00;
      txs_chan_q <= 5'h00;
      txs_addr_q <= 24'h00_0000;
      rx_descriptor_pointer_q <= 24'h00_0000;
      rx_buffer_pointer_q <= 24'h00_0000;
      next_rx_descriptor_pointer_q <= 24'h00_0000;
      buffer_length_words_q <= '0;
      buffer_done_irq_enable_q <= 1'b0;
      queue_stop_flag_q <= 1'b0;
      words_q <= '0;
      received_byte_count_q <= '0;
      lo_q <= 8'h00;
      have_lo_q <= 1'b0;
      end_pend_q <= 1'b0;
      end_kind_q <= 3'h0;
      word_q <= 16'h0000;
      tx_desc_valid <= 1'b0;
      tx_desc_chan <= 5'h00;
      tx_desc_addr <= 24'h00_0000;
      buffer_done_irq <= 1'b0;
      queue_stop_irq <= 1'b0;
    end else begin
      tx_desc_valid <= 1'b0;
      buffer_done_irq <= 1'b0;
      queue_stop_irq <= 1'b0;
      unique case (state_q)
        hdlc_rx_dma_pkg::S_IDLE, hdlc_rx_dma_pkg::S_HALT: begin
          if (take_start) begin
            chan_q <= rx_command_reg_q[5:0];
            state_q <= hdlc_rx_dma_pkg::S_TBL_HI;
          end else if (take_cont) begin
            dw_q <= 3'h1;
            state_q <= hdlc_rx_dma_pkg::S_DESC;
          end else if (take_txs) begin
            txs_chan_q <= tx_store_chan;
            txs_addr_q <= tx_store_addr;
            state_q <= hdlc_rx_dma_pkg::S_TXW_HI;
          end
        end
        hdlc_rx_dma_pkg::S_TBL_HI: if (done) begin
          hi_q <= mem_rdata[7:0];
          state_q <= hdlc_rx_dma_pkg::S_TBL_LO;
        end
        hdlc_rx_dma_pkg::S_TBL_LO: if (done) begin
          dw_q <= 3'h0;
          if (chan_q[hdlc_rx_dma_pkg::CMD_RX_BIT]) begin
            rx_descriptor_pointer_q <= {hi_q, mem_rdata[15:1], 1'b0};
            state_q <= hdlc_rx_dma_pkg::S_DESC;
          end else begin
            tx_desc_valid <= 1'b1;
            tx_desc_chan <= chan_q[4:0];
            tx_desc_addr <= {hi_q, mem_rdata[15:1], 1'b0};
            state_q <= hdlc_rx_dma_pkg::S_IDLE;
          end
        end
        hdlc_rx_dma_pkg::S_DESC: if (done) begin
          dw_q <= dw_q + 3'h1;
          unique case (dw_q)
            3'h0: begin
              buffer_done_irq_enable_q <= mem_rdata[hdlc_rx_dma_pkg::IBC_BIT];
              queue_stop_flag_q <= mem_rdata[hdlc_rx_dma_pkg::EOQ_BIT];
              buffer_length_words_q <= mem_rdata[hdlc_rx_dma_pkg::LEN_W-1:0];
              if (mem_rdata[hdlc_rx_dma_pkg::EOQ_BIT]) begin
                queue_stop_irq <= 1'b1;
                state_q <= hdlc_rx_dma_pkg::S_HALT;
              end
            end
            3'h1: rx_buffer_pointer_q[23:16] <= mem_rdata[7:0];
            3'h2: rx_buffer_pointer_q[15:0] <= {mem_rdata[15:1], 1'b0};
            3'h3: next_rx_descriptor_pointer_q[23:16] <= mem_rdata[7:0];
            default: begin
              next_rx_descriptor_pointer_q[15:0] <= {mem_rdata[15:1], 1'b0};
              if (len_eff == '0) begin
                dw_q <= 3'h0;
                rx_descriptor_pointer_q <= {next_rx_descriptor_pointer_q[23:16],
                  mem_rdata[15:1], 1'b0};
              end else begin
                state_q <= hdlc_rx_dma_pkg::S_STAT0;
              end
            end
          endcase
        end
        hdlc_rx_dma_pkg::S_STAT0: if (done) begin
          words_q <= '0;
          received_byte_count_q <= '0;
          have_lo_q <= 1'b0;
          end_pend_q <= 1'b0;
          state_q <= hdlc_rx_dma_pkg::S_FILL;
        end
        hdlc_rx_dma_pkg::S_FILL: begin
          if (take) begin
            if (!rx_nobyte) begin
              received_byte_count_q <= received_byte_count_q + 1'b1;
              if (have_lo_q) begin
                word_q <= {rx_byte, lo_q};
              end else begin
                word_q <= {8'h00, rx_byte};
                lo_q <= rx_byte;
                have_lo_q <= 1'b1;
              end
            end
            if (rx_last) begin
              end_pend_q <= 1'b1;
              end_kind_q <= rx_end_kind;
            end
            if (!rx_nobyte && (have_lo_q || rx_last)) begin
              state_q <= hdlc_rx_dma_pkg::S_WORD;
            end else if (rx_last) begin
              state_q <= have_lo_q ? hdlc_rx_dma_pkg::S_WORD : hdlc_rx_dma_pkg::S_STAT;
            end
          end else if (abort_pend_q) begin
            end_pend_q <= 1'b1;
            end_kind_q <= hdlc_rx_dma_pkg::END_ABORT;
            state_q <= hdlc_rx_dma_pkg::S_STAT;
          end
        end
        hdlc_rx_dma_pkg::S_WORD: if (done) begin
          words_q <= words_q + 1'b1;
          have_lo_q <= 1'b0;
          if (end_pend_q || words_q + 1'b1 == len_eff) begin
            state_q <= hdlc_rx_dma_pkg::S_STAT;
          end else begin
            state_q <= hdlc_rx_dma_pkg::S_FILL;
          end
        end
        hdlc_rx_dma_pkg::S_STAT: if (done) begin
          buffer_done_irq <= buffer_done_irq_enable_q;
          rx_descriptor_pointer_q <= next_rx_descriptor_pointer_q;
          dw_q <= 3'h0;
          state_q <= hdlc_rx_dma_pkg::S_DESC;
        end
        hdlc_rx_dma_pkg::S_TXW_HI: if (done) begin
          state_q <= hdlc_rx_dma_pkg::S_TXW_LO;
        end
        hdlc_rx_dma_pkg::S_TXW_LO: if (done) begin
          state_q <= hdlc_rx_dma_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Stream and store handshakes, taken only where the sequencer can act
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ready <= 1'b0;
      tx_store_ready <= 1'b0;
    end else begin
      rx_ready <= state_q == hdlc_rx_dma_pkg::S_FILL && !take && !abort_pend_q;
      tx_store_ready <= state_q == hdlc_rx_dma_pkg::S_IDLE && !take_txs
        && !start_pend_q && !set_start;
    end
  end

  // Pending commands, a new request wins over its own clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pend_q <= 1'b0;
      cont_pend_q <= 1'b0;
      abort_pend_q <= 1'b0;
      cause_q <= 2'b00;
    end else begin
      start_pend_q <= set_start | (start_pend_q & ~take_start);
      cont_pend_q <= set_cont | (cont_pend_q & ~take_cont & ~take_start);
      abort_pend_q <= set_abort
        | (abort_pend_q & ~(state_q == hdlc_rx_dma_pkg::S_FILL && !take));
      cause_q[hdlc_rx_dma_pkg::CAUSE_QSTOP_BIT] <= queue_stop_irq
        | (cause_q[hdlc_rx_dma_pkg::CAUSE_QSTOP_BIT]
        & ~(wr_pend_q && wr_addr_q == hdlc_rx_dma_pkg::OFS_CAUSE
        && hwdata[hdlc_rx_dma_pkg::CAUSE_QSTOP_BIT]));
      cause_q[hdlc_rx_dma_pkg::CAUSE_BDONE_BIT] <= buffer_done_irq
        | (cause_q[hdlc_rx_dma_pkg::CAUSE_BDONE_BIT]
        & ~(wr_pend_q && wr_addr_q == hdlc_rx_dma_pkg::OFS_CAUSE
        && hwdata[hdlc_rx_dma_pkg::CAUSE_BDONE_BIT]));
    end
  end

  // Register read mux
  always_comb begin
    unique case (haddr[7:0])
      hdlc_rx_dma_pkg::OFS_TABLE_BASE: rd_mux = {8'h00, table_base_reg_q};
      hdlc_rx_dma_pkg::OFS_RX_CMD: rd_mux = {16'h0000, rx_command_reg_q};
      hdlc_rx_dma_pkg::OFS_STATUS: rd_mux = {3'h0, received_byte_count_q, 2'h0,
        chan_q, 6'h00, state_q == hdlc_rx_dma_pkg::S_HALT,
        state_q != hdlc_rx_dma_pkg::S_IDLE};
      hdlc_rx_dma_pkg::OFS_CAUSE: rd_mux = {30'h0000_0000, cause_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      table_base_reg_q <= hdlc_rx_dma_pkg::TABLE_BASE_RST;
      rx_command_reg_q <= hdlc_rx_dma_pkg::RX_CMD_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (wr_pend_q && wr_addr_q == hdlc_rx_dma_pkg::OFS_TABLE_BASE) begin
        table_base_reg_q <= hwdata[23:0];
      end
      if (bus_wr) begin
        rx_command_reg_q <= hwdata[15:0];
      end
      if (hsel && htrans[1] && hready) begin
        wr_pend_q <= hwrite;
        wr_addr_q <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end else begin
        wr_pend_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/hdlc_rx_dma_properties.sv ====
// Port checker for the receive descriptor mover
`default_nettype none
module hdlc_rx_dma_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_desc_valid,
  input wire logic buffer_done_irq,
  input wire logic queue_stop_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_start_cmd;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h04 ##1 hwdata[8];
  endsequence
  sequence s_table_read;
    ##[1:6] (mem_req && !mem_we);
  endsequence
  property p_start_reads;
    s_start_cmd |-> s_table_read;
  endproperty
  property p_aligned;
    mem_req |-> !mem_addr[0];
  endproperty
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  property p_release;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  property p_rx_gap;
    rx_valid && rx_ready |=> !rx_ready;
  endproperty
  property p_bdone_pulse;
    buffer_done_irq |=> !buffer_done_irq;
  endproperty
  property p_qstop_halt;
    queue_stop_irq |=> !mem_req [*6];
  endproperty
  property p_tx_pulse;
    tx_desc_valid |=> !tx_desc_valid;
  endproperty
  a_start_reads: assert property (p_start_reads) else $error("no table read after start");
  a_aligned: assert property (p_aligned) else $error("odd memory address");
  a_hold: assert property (p_hold) else $error("memory request changed");
  a_release: assert property (p_release) else $error("request kept after ack");
  a_rx_gap: assert property (p_rx_gap) else $error("stream ready not dropped");
  a_bdone_pulse: assert property (p_bdone_pulse) else $error("long buffer done");
  a_qstop_halt: assert property (p_qstop_halt) else $error("access after stop");
  a_tx_pulse: assert property (p_tx_pulse) else $error("long pointer pulse");
endmodule
bind hdlc_rx_descriptor_dma hdlc_rx_dma_checker hdlc_rx_dma_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_desc_valid(tx_desc_valid),
  .buffer_done_irq(buffer_done_irq), .queue_stop_irq(queue_stop_irq)
);
`default_nettype wire

// ==== test/mem_host_model.sv ====
// Shared memory model on the 16-bit memory port
`default_nettype none
module mem_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:511];
  logic [1:0] wait_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 16'h5A5A;
    end else if (mem_req && mem_ack) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      if (mem_we) begin
        mem[mem_addr[9:1]] <= mem_wdata;
      end
    end else if (mem_req && (!slow || wait_q == 2'h3)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[9:1]];
    end else begin
      wait_q <= wait_q + 2'h1;
      // Idle and wait cycles invert the read word; it is held only on the cycle that drops the ack
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ==== test/hdlc_rx_descriptor_dma_test.sv ====
// Self-checking bench for the receive descriptor mover
`default_nettype none
module hdlc_rx_descriptor_dma_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] kind;
    logic [3:0] flags;
  } row_t;
  localparam row_t ROWS [5] = '{'{3'h0, 4'h8}, '{3'h1, 4'h9}, '{3'h2, 4'h4}, '{3'h3, 4'h6},
    '{3'h4, 4'h5}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, mem_req, mem_we, mem_ack;
  logic rx_valid, rx_last, rx_nobyte, rx_ready, tx_store_valid, tx_store_ready;
  logic tx_desc_valid, buffer_done_irq, queue_stop_irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, rx_end_kind;
  logic [23:0] mem_addr, tx_store_addr, tx_desc_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [7:0] rx_byte;
  logic [4:0] tx_store_chan, tx_desc_chan;
  wire logic hready;
  int err_total, total_checks;
  assign hready = hreadyout;
  hdlc_rx_descriptor_dma hdlc_rx_descriptor_dma_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last),
    .rx_nobyte(rx_nobyte), .rx_end_kind(rx_end_kind), .rx_ready(rx_ready),
    .tx_store_valid(tx_store_valid), .tx_store_chan(tx_store_chan),
    .tx_store_addr(tx_store_addr), .tx_store_ready(tx_store_ready),
    .tx_desc_valid(tx_desc_valid), .tx_desc_chan(tx_desc_chan), .tx_desc_addr(tx_desc_addr),
    .buffer_done_irq(buffer_done_irq), .queue_stop_irq(queue_stop_irq)
  );
  mem_host_model mem_host_model_inst (
    .hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic mw(input logic [9:0] a, input logic [15:0] d);
    mem_host_model_inst.mem[a[9:1]] = d;
  endtask
  function automatic logic [31:0] mr(input logic [9:0] a);
    return {16'h0000, mem_host_model_inst.mem[a[9:1]]};
  endfunction
  task automatic desc(input logic [9:0] a, input logic [15:0] w0, input logic [15:0] bp,
      input logic [15:0] nxt);
    mw(a, w0);
    mw(a + 10'h2, 16'h0000);
    mw(a + 10'h4, bp);
    mw(a + 10'h6, 16'h0000);
    mw(a + 10'h8, nxt);
    mw(a + 10'hA, 16'hDEAD);
  endtask
  task automatic send(input logic [7:0] b, input logic lst, input logic nob, input logic [2:0] k);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    rx_last <= lst;
    rx_nobyte <= nob;
    rx_end_kind <= k;
    @(posedge hclk);
    while (rx_ready !== 1'b1) @(posedge hclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    final_report();
  end
  initial begin
    {hresetn, hsel, hwrite, slow, rx_valid, rx_last, rx_nobyte, tx_store_valid} = 8'h00;
    {haddr, hwdata, htrans, rx_byte, rx_end_kind} = 77'h0;
    {tx_store_chan, tx_store_addr} = 29'h0;
    hsize = 3'h2;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 8'h00, 32'h0000_0100);
    ahb(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    mw(10'h1FC, 16'h0000);
    mw(10'h1FE, 16'h0201);
    for (int i = 0; i < 5; i++) begin
      desc(10'h200, 16'h2008, 16'h0300, 16'h0240);
      desc(10'h240, 16'h1000, 16'h0300, 16'h0240);
      slow <= i[0];
      ahb(1'b1, 8'h04, 32'h0000_013F);
      send(8'h5A, 1'b0, 1'b0, 3'h0);
      send(8'h00, 1'b1, 1'b1, ROWS[i].kind);
      while (buffer_done_irq !== 1'b1) @(posedge hclk);
      while (queue_stop_irq !== 1'b1) @(posedge hclk);
      ahb(1'b0, 8'h0C, 32'h0000_0000);
      check(rd, 32'h0000_0003);
      ahb(1'b1, 8'h0C, 32'h0000_0003);
      check(mr(10'h20A), {16'h0000, ROWS[i].flags, 12'h001});
      check(mr(10'h300), 32'h0000_005A);
      check(mr(10'h200) | mr(10'h204) << 16, 32'h0300_2008);
    end
    // Zero-size skip, then a full buffer and a continuation buffer
    mw(10'h10C, 16'h0000);
    mw(10'h10E, 16'h0260);
    desc(10'h260, 16'h0000, 16'h0320, 16'h0280);
    desc(10'h280, 16'h2001, 16'h0320, 16'h02A0);
    desc(10'h2A0, 16'h0001, 16'h0340, 16'h0240);
    ahb(1'b1, 8'h04, 32'h0000_0121);
    send(8'h11, 1'b0, 1'b0, 3'h0);
    send(8'h22, 1'b0, 1'b0, 3'h0);
    send(8'h33, 1'b1, 1'b0, 3'h0);
    while (queue_stop_irq !== 1'b1) @(posedge hclk);
    ahb(1'b0, 8'h08, 32'h0000_0000);
    check({31'h0, rd[1]}, 32'h0000_0001);
    check(mr(10'h320), 32'h0000_2211);
    check(mr(10'h28A), 32'h0000_0002);
    check(mr(10'h2AA), 32'h0000_8001);
    check(mr(10'h340), 32'h0000_0033);
    // Continue past the stop, then abort the open buffer by command
    mw(10'h240, 16'h2004);
    ahb(1'b1, 8'h04, 32'h0000_0200);
    while (rx_ready !== 1'b1) @(posedge hclk);
    check(mr(10'h24A), 32'h0000_0000);
    ahb(1'b1, 8'h04, 32'h0000_0400);
    while (buffer_done_irq !== 1'b1) @(posedge hclk);
    check(mr(10'h24A), 32'h0000_4000);
    // Second reset in mid-run
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check({26'h0, hreadyout, hresp, mem_req, rx_ready, queue_stop_irq, tx_desc_valid},
      32'h0000_0020);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    ahb(1'b1, 8'h00, 32'h0000_0100);
    tx_store_valid <= 1'b1;
    tx_store_chan <= 5'h03;
    tx_store_addr <= 24'h12_3456;
    @(posedge hclk);
    while (tx_store_ready !== 1'b1) @(posedge hclk);
    tx_store_valid <= 1'b0;
    while ((mem_req & mem_ack) !== 1'b1 || mem_addr !== 24'h00_011A) @(posedge hclk);
    @(posedge hclk);
    ahb(1'b1, 8'h04, 32'h0000_0103);
    while (tx_desc_valid !== 1'b1) @(posedge hclk);
    check({3'h0, tx_desc_chan, tx_desc_addr}, 32'h0312_3456);
    check(mr(10'h118), 32'h0000_0012);
    check(mr(10'h11A), 32'h0000_3456);
    final_report();
  end
endmodule
`default_nettype wire
